/* fprs_host.sv */
// host controller that sequences power-on and hardware reset of the flash
`timescale 1ns/1ps
module fprs_host (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              supply_good_i,
  input  wire logic              ready_busy_out_i,
  input  wire logic              reset_req_i,
  input  wire logic              access_req_i,
  input  wire logic              access_done_i,
  output fprs_pkg::fprs_pins_t   pins_o,
  output fprs_pkg::fprs_stat_t   stat_o
);
  import fprs_pkg::*;

  typedef struct packed {
    fprs_state_t      state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rph;
    logic [CNT_W-1:0] ceh;
    fprs_pins_t       pins;
    fprs_stat_t       stat;
  } fprs_host_t;

  fprs_host_t st_r;
  fprs_host_t st_nxt;
  logic       supply_s;
  logic       rdy_s;

  // supply level and ready pin come from outside the clock domain
  fprs_sync u_sync_sup (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .d_i       (supply_good_i),
    .rst_val_i (1'b0),
    .q_o       (supply_s)
  );

  // ready pin inverted in and out; reads ready for two edges after reset, which no state uses
  fprs_sync u_sync_rdy (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .d_i       (~ready_busy_out_i),
    .rst_val_i (1'b1),
    .q_o       (rdy_s)
  );

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 16'h0001;
  endfunction

  function automatic logic reached(input logic [CNT_W-1:0] v, input int unsigned lim);
    reached = (32'(v) >= lim);
  endfunction

  // next-state logic
  always_comb begin
    st_nxt     = st_r;
    st_nxt.cnt = sat_inc(st_r.cnt);
    st_nxt.rph = sat_inc(st_r.rph);
    st_nxt.ceh = st_r.pins.select_n ? sat_inc(st_r.ceh) : 16'h0000;
    case (st_r.state)
      FPRS_POWER_WAIT: begin
        // flash ignores controls here, so select stays high regardless
        st_nxt.pins.select_n = 1'b1;
        st_nxt.stat          = 2'b01;
        if (!supply_s) begin
          st_nxt.cnt = 16'h0000;
          st_nxt.rph = 16'h0000; // reset time counts from supply setup end
        end else if (!st_r.pins.reset_n && !reached(st_r.cnt, SUPPLY_CYC)) begin
          st_nxt.rph = 16'h0000;
        end
        if (supply_s && reached(st_r.cnt, SUPPLY_CYC)) begin
          if (!st_r.pins.reset_n) begin
            st_nxt.state = FPRS_RESET_LOW; // flash stays in hardware reset
          end else begin
            st_nxt.state = FPRS_RESET_HIGH; // flash goes to standby
            st_nxt.cnt   = 16'h0000;
          end
        end else if (reset_req_i) begin
          st_nxt.pins.reset_n = 1'b0;
        end
      end
      FPRS_RESET_LOW: begin
        st_nxt.pins.reset_n  = 1'b0;
        st_nxt.pins.select_n = 1'b1;
        st_nxt.stat          = 2'b01;
        // hold long enough for both pulse width and reset-low-to-select
        if (reached(st_r.rph, RPH_CYC) && reached(st_r.cnt, RP_CYC) && !reset_req_i) begin
          st_nxt.pins.reset_n = 1'b1;
          st_nxt.state        = FPRS_RESET_HIGH;
          st_nxt.cnt          = 16'h0000;
        end
      end
      FPRS_RESET_HIGH: begin
        if (reached(st_r.cnt, RH_CYC)) begin
          st_nxt.state = FPRS_READY_WAIT;
          st_nxt.cnt   = 16'h0000;
        end
      end
      FPRS_READY_WAIT: begin
        // busy low during reset work; select allowed at once when ready
        if (rdy_s && reached(st_r.cnt, RB_CYC)) begin
          st_nxt.state = FPRS_IDLE;
          st_nxt.stat  = 2'b10;
        end
      end
      FPRS_IDLE: begin
        st_nxt.stat = rdy_s ? 2'b10 : 2'b01;
        if (reset_req_i) begin
          // later reset becomes a warm reset in the flash
          st_nxt.state        = FPRS_RESET_LOW;
          st_nxt.pins.reset_n = 1'b0;
          st_nxt.stat         = 2'b01;
          st_nxt.cnt          = 16'h0000;
          st_nxt.rph          = 16'h0000;
        end else if (access_req_i && rdy_s && reached(st_r.ceh, CEH_CYC)) begin
          st_nxt.state         = FPRS_SELECT;
          st_nxt.pins.select_n = 1'b0; // fresh falling edge starts a valid read
        end
      end
      FPRS_SELECT: begin
        if (access_done_i || reset_req_i) begin
          st_nxt.state         = FPRS_IDLE;
          st_nxt.pins.select_n = 1'b1;
        end
      end
      default: begin
        st_nxt.state = FPRS_POWER_WAIT;
      end
    endcase
    if (!supply_s && st_r.state != FPRS_POWER_WAIT) begin
      // supply loss forces a full cold sequence
      st_nxt.state         = FPRS_POWER_WAIT;
      st_nxt.pins.select_n = 1'b1;
      st_nxt.stat          = 2'b01;
      st_nxt.cnt           = 16'h0000;
    end
  end

  // state register; reset drives flash reset low with select high
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r.state <= FPRS_POWER_WAIT;
      st_r.cnt   <= 16'h0000;
      st_r.rph   <= 16'h0000;
      st_r.ceh   <= 16'h0000;
      st_r.pins  <= 2'b01;
      st_r.stat  <= 2'b01;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_o = st_r.pins;
  assign stat_o = st_r.stat;
endmodule // fprs_host

/* fprs_pkg.sv */
// package of constants and carrier types for the flash power-on reset sequencer host
// Contract
// - the host starts no access until 50 us after both supplies are good.
// - after cold reset a read needs a fresh select or enable fall or an address change.
// - a reset pulse is at least 200 ns low and pulse plus high-to-select is at least 50 us.
// - chip select goes low no earlier than 50 us after reset went low.
// - reset is high for at least 50 ns before chip select goes low.
// - a reset during power-up ends at the latest of the supply setups and the reset time; the host ends it at supply setup plus reset time.
// - once ready/busy is high the host may select at once.
// - chip select once high stays high for at least 20 ns.
package fprs_pkg;
  localparam int unsigned CLK_MHZ               = 200;
  localparam int unsigned CORE_SUPPLY_SETUP_US  = 50;
  localparam int unsigned IO_SUPPLY_SETUP_US    = 50;
  localparam int unsigned RESET_LOW_SEL_US      = 50;
  localparam int unsigned RESET_PULSE_NS        = 200;
  localparam int unsigned RESET_HIGH_SEL_NS     = 50;
  localparam int unsigned READY_ACCESS_NS       = 0;
  localparam int unsigned SELECT_HIGH_NS        = 20;
  // least times round up; only the select-high time is held to at least one cycle, and RB_CYC is zero
  localparam int unsigned SUPPLY_CYC = ((CORE_SUPPLY_SETUP_US > IO_SUPPLY_SETUP_US) ?
                                        CORE_SUPPLY_SETUP_US : IO_SUPPLY_SETUP_US) * CLK_MHZ;
  localparam int unsigned RPH_CYC    = RESET_LOW_SEL_US * CLK_MHZ;
  localparam int unsigned RP_CYC     = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RH_CYC     = (RESET_HIGH_SEL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CEH_CYC0   = (SELECT_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CEH_CYC    = (CEH_CYC0 < 1) ? 1 : CEH_CYC0;
  localparam int unsigned RB_CYC     = READY_ACCESS_NS;
  localparam int unsigned CNT_W      = 16;

  // host sequencing states
  typedef enum logic [2:0] {
    FPRS_POWER_WAIT,
    FPRS_RESET_LOW,
    FPRS_RESET_HIGH,
    FPRS_READY_WAIT,
    FPRS_IDLE,
    FPRS_SELECT
  } fprs_state_t;

  // pins toward the flash
  typedef struct packed {
    logic reset_n;
    logic select_n;
  } fprs_pins_t;

  // user side status
  typedef struct packed {
    logic ready;
    logic busy;
  } fprs_stat_t;
endpackage

/* fprs_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fprs_sync (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic d_i,
  input  wire logic rst_val_i,
  output logic      q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } fprs_sync_t;
  fprs_sync_t st_r;
  fprs_sync_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // reset value chosen per instance as a constant tie
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= 2'b00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2 ^ rst_val_i;
endmodule // fprs_sync

/* fprs_host_chk.sv */
// port checks of the reset sequencing host
`timescale 1ns/1ps
module fprs_host_chk (
  input wire logic                 clk_i,
  input wire logic                 nrst_i,
  input wire logic                 supply_good_i,
  input wire logic                 ready_busy_out_i,
  input wire logic                 reset_req_i,
  input wire logic                 access_req_i,
  input wire logic                 access_done_i,
  input wire fprs_pkg::fprs_pins_t pins_o,
  input wire fprs_pkg::fprs_stat_t stat_o
);
  import fprs_pkg::*;
  int lo, hi, sup;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence sel_fall; $fell(pins_o.select_n); endsequence
  sequence sel_high4; pins_o.select_n [*4]; endsequence
  // cycles of reset low, reset high and supply good; counts alone avoid long repeats
  always_ff @(posedge clk_i) begin
    lo <= (!nrst_i || pins_o.reset_n) ? 0 : lo + 1;
    hi <= (!nrst_i || !pins_o.reset_n) ? 0 : hi + 1;
    sup <= supply_good_i ? sup + 1 : 0;
  end
  rh_gap_a: assert property (sel_fall |-> hi >= RH_CYC)
    else $error("select too soon after reset");
  rst_pulse_a: assert property ($rose(pins_o.reset_n) |-> lo + RH_CYC >= RPH_CYC)
    else $error("reset pulse too short");
  supply_first_a: assert property (sel_fall |-> sup >= SUPPLY_CYC)
    else $error("select before supply setup");
  sel_in_rst_a: assert property (!pins_o.reset_n |-> pins_o.select_n)
    else $error("select during reset");
  ceh_hold_a: assert property ($rose(pins_o.select_n) |-> sel_high4)
    else $error("select high too short");
  sel_cause_a: assert property (sel_fall |-> $past(access_req_i))
    else $error("select without request");
  done_free_a: assert property (!pins_o.select_n && access_done_i |-> ##[1:2] pins_o.select_n)
    else $error("select not released");
  busy_rst_a: assert property (!pins_o.reset_n |-> stat_o.busy && !stat_o.ready)
    else $error("ready during reset");
  warm_go_a: assert property (stat_o.ready && pins_o.select_n && reset_req_i |=> !pins_o.reset_n)
    else $error("reset request not taken");
endmodule // fprs_host_chk

/* fprs_flash_model.sv */
// behavioural flash: cold and warm reset with the ready/busy pin
`timescale 1ns/1ps
module fprs_flash_model (
  input  wire logic clk_i,
  input  wire logic supply_good_i,
  input  wire logic reset_n_i,
  input  wire logic select_n_i,
  output logic      ready_busy_out_o
);
  import fprs_pkg::*;
  typedef enum logic [1:0] {FM_POR, FM_WARM, FM_HOLD, FM_STBY} fprs_fm_t;
  fprs_fm_t st = FM_POR;
  int cnt = 0;
  // select is never looked at, so a low select in reset changes nothing
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (!supply_good_i) begin
      st <= FM_POR;
      cnt <= 0;
    end else case (st)
      FM_POR: if (cnt >= SUPPLY_CYC) begin
        st <= reset_n_i ? FM_STBY : FM_WARM;
        cnt <= 0;
      end
      FM_WARM: if (cnt >= RPH_CYC) st <= reset_n_i ? FM_STBY : FM_HOLD;
      FM_HOLD: if (reset_n_i) st <= FM_STBY;
      default: if (!reset_n_i) begin
        st <= FM_WARM;
        cnt <= 0;
      end
    endcase
  end
  assign ready_busy_out_o = (st == FM_STBY);
endmodule // fprs_flash_model

/* test_fprs_host.sv */
// self-checking bench for the reset sequencing host
`timescale 1ns/1ps
module test_fprs_host;
  import fprs_pkg::*;
  logic clk_i = 1'h0, nrst_i = 1'h0, supply_good_i = 1'h0, reset_req_i = 1'h0;
  logic access_req_i = 1'h0, access_done_i = 1'h0;
  wire logic ready_busy_out_i;
  fprs_pins_t pins_o;
  fprs_stat_t stat_o;
  int miscompares = 0, samples_checked = 0, t, h;
  always #2.5 clk_i = ~clk_i;
  fprs_host dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .supply_good_i(supply_good_i),
    .ready_busy_out_i(ready_busy_out_i), .reset_req_i(reset_req_i),
    .access_req_i(access_req_i), .access_done_i(access_done_i), .pins_o(pins_o), .stat_o(stat_o));
  fprs_flash_model flash_u (.clk_i(clk_i), .supply_good_i(supply_good_i),
    .reset_n_i(pins_o.reset_n), .select_n_i(pins_o.select_n), .ready_busy_out_o(ready_busy_out_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // supply setup, then reset held low, then the high gap before select
  // with reset left high only the supply setup bounds the wait
  function automatic int cold_min(input bit rst_low);
    return rst_low ? int'(SUPPLY_CYC + RPH_CYC + RH_CYC) : int'(SUPPLY_CYC);
  endfunction
  task automatic until_ready();
    t = 0;
    while (stat_o.ready !== 1'h1 && t < 30000) begin
      cyc(1);
      t++;
    end
    chk(stat_o, 2'h2);
  endtask
  // one access; the grant wait also covers a refused back-to-back request
  task automatic access(input int hold);
    int w = 0;
    access_req_i = 1'h1;
    while (pins_o.select_n !== 1'h0 && w < 9) begin
      cyc(1);
      w++;
    end
    access_req_i = 1'h0;
    chk(pins_o.select_n, 1'h0);
    cyc(hold);
    access_done_i = 1'h1;
    cyc(1);
    access_done_i = 1'h0;
    cyc(1);
    chk(pins_o.select_n, 1'h1);
  endtask
  task automatic power_up(input bit rst_low);
    cyc(1 + $urandom % 40);
    supply_good_i = 1'h1;
    until_ready();
    chk(t >= cold_min(rst_low), 1'h1);
    chk(pins_o.reset_n, 1'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hb0a7));
    cyc(6);
    chk({pins_o, stat_o}, 4'h5);
    nrst_i = 1'h1;
    access_req_i = 1'h1;
    cyc(20);
    access_req_i = 1'h0;
    chk(pins_o.select_n, 1'h1);
    power_up(1'b1);
    $display("test power_up done");
    repeat (8) access($urandom % 13);
    $display("test access done");
    h = 1 + $urandom % 20;
    reset_req_i = 1'h1;
    cyc(h);
    reset_req_i = 1'h0;
    chk(pins_o.reset_n, 1'h0);
    until_ready();
    chk(t + h >= RPH_CYC, 1'h1);
    access(0);
    $display("test warm_reset done");
    supply_good_i = 1'h0;
    cyc(8);
    // a supply loss leaves reset high, so the restart takes the standby path
    chk({pins_o.reset_n, stat_o.ready}, 2'h2);
    power_up(1'b0);
    access(3);
    $display("test supply_loss done");
    tally_and_finish();
  end
  // watchdog well past the three cold and warm sequences
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule // test_fprs_host
bind fprs_host fprs_host_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
  .supply_good_i(supply_good_i), .ready_busy_out_i(ready_busy_out_i), .reset_req_i(reset_req_i),
  .access_req_i(access_req_i), .access_done_i(access_done_i), .pins_o(pins_o), .stat_o(stat_o));
